// [hw/pmr_pkg.sv]
// Shared constants and types for the PHY management register set
`default_nettype none
package pmr_pkg;
  localparam int unsigned NUM_PORTS = 2;
  // Management addresses of the two PHY ports
  localparam logic [4:0] PHY_ADDR_P0 = 5'h01;
  localparam logic [4:0] PHY_ADDR_P1 = 5'h02;
  // Register addresses
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ID_UP = 5'h02;
  localparam logic [4:0] REG_ID_LO = 5'h03;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LPA = 5'h05;
  localparam logic [4:0] REG_LAST = 5'h05;
  // Control bit positions
  localparam int unsigned CTRL_FORCE_100 = 13;
  localparam int unsigned CTRL_AN_EN = 12;
  localparam int unsigned CTRL_PWR_DOWN = 11;
  localparam int unsigned CTRL_RESTART_AN = 9;
  localparam int unsigned CTRL_FULL_DUP = 8;
  localparam int unsigned CTRL_FORCE_MDI = 4;
  localparam int unsigned CTRL_MDIX_DIS = 3;
  localparam int unsigned CTRL_FEF_DIS = 2;
  localparam int unsigned CTRL_TX_DIS = 1;
  localparam int unsigned CTRL_LED_DIS = 0;
  localparam logic [15:0] CTRL_WR_MASK = 16'h391f;
  localparam logic [15:0] CTRL_RESET = 16'h1000;
  // Status bit positions and constant part
  localparam int unsigned STAT_AN_DONE = 5;
  localparam int unsigned STAT_FEF = 4;
  localparam int unsigned STAT_LINK = 2;
  localparam logic [15:0] STAT_FIXED = 16'h7808;
  // Advertisement bits
  localparam int unsigned ADV_PAUSE = 10;
  localparam int unsigned ADV_100_FULL = 8;
  localparam int unsigned ADV_100_HALF = 7;
  localparam int unsigned ADV_10_FULL = 6;
  localparam int unsigned ADV_10_HALF = 5;
  localparam logic [15:0] ADV_WR_MASK = 16'h05e0;
  localparam logic [15:0] ADV_SELECTOR = 16'h0001;
  localparam logic [15:0] ADV_RESET = 16'h05e1;
  // Identifier words, values arbitrary
  localparam logic [15:0] ID_UPPER_WORD = 16'h0a5a;
  localparam logic [15:0] ID_LOWER_WORD = 16'h5c30;
  // Serial frame counts
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] ADDR_BITS_LAST = 6'h09;
  localparam logic [5:0] DATA_BITS_LAST = 6'h0f;
  typedef enum logic [2:0] {
    PMR_PRE, PMR_ST1, PMR_OPC, PMR_ADDR, PMR_TA, PMR_WDAT, PMR_RDAT
  } pmr_state_e;
endpackage : pmr_pkg
`default_nettype wire

// [hw/pmr_port_regs.sv]
// Register set of one PHY port with two read ports and one write port
`default_nettype none
module pmr_port_regs (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wr_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [4:0] rd_a_addr_i,
  output logic [15:0] rd_a_data_o,
  input wire logic [4:0] rd_b_addr_i,
  output logic [15:0] rd_b_data_o,
  input wire logic an_complete_i,
  input wire logic far_fault_i,
  input wire logic link_up_i,
  output logic [15:0] ctrl_o,
  output logic [15:0] adv_o,
  output logic restart_an_o
);
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] adv_r, adv_nxt;
  logic restart_r, restart_nxt;
  logic [15:0] stat_w;

  // Fault reported only while detection is enabled
  assign stat_w = pmr_pkg::STAT_FIXED
    | {10'h000, an_complete_i, far_fault_i & ~ctrl_r[pmr_pkg::CTRL_FEF_DIS], 1'b0, link_up_i, 2'h0};

  function automatic logic [15:0] rd_word(input logic [4:0] a);
    logic [15:0] d;
    d = 16'h0000;
    if (a == pmr_pkg::REG_CTRL)
      d = ctrl_r;
    else if (a == pmr_pkg::REG_STAT)
      d = stat_w;
    else if (a == pmr_pkg::REG_ID_UP)
      d = pmr_pkg::ID_UPPER_WORD;
    else if (a == pmr_pkg::REG_ID_LO)
      d = pmr_pkg::ID_LOWER_WORD;
    else if (a == pmr_pkg::REG_ADV)
      d = adv_r;
    return d;
  endfunction : rd_word

  // Process form: reads must follow register and status changes too
  always_comb
  begin
    rd_a_data_o = rd_word(rd_a_addr_i);
    rd_b_data_o = rd_word(rd_b_addr_i);
  end
  assign ctrl_o = ctrl_r;
  assign adv_o = adv_r;
  assign restart_an_o = restart_r;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    adv_nxt = adv_r;
    restart_nxt = 1'b0;
    if (wr_i && wr_addr_i == pmr_pkg::REG_CTRL)
    begin
      ctrl_nxt = wr_data_i & pmr_pkg::CTRL_WR_MASK;
      restart_nxt = wr_data_i[pmr_pkg::CTRL_RESTART_AN];
    end
    else if (wr_i && wr_addr_i == pmr_pkg::REG_ADV)
    begin
      adv_nxt = (wr_data_i & pmr_pkg::ADV_WR_MASK) | pmr_pkg::ADV_SELECTOR;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_r <= pmr_pkg::CTRL_RESET;
      adv_r <= pmr_pkg::ADV_RESET;
      restart_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      adv_r <= adv_nxt;
      restart_r <= restart_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  cap_bits_a: assert property ((rd_a_addr_i == pmr_pkg::REG_STAT) |-> rd_a_data_o[14:11] == 4'hf)
    else $error("capability bits not all one");
  no_t4_a: assert property ((rd_b_addr_i == pmr_pkg::REG_STAT) |-> !rd_b_data_o[15])
    else $error("T4 capability reported");
  an_done_a: assert property ((rd_a_addr_i == pmr_pkg::REG_STAT) |-> rd_a_data_o[5] == an_complete_i)
    else $error("negotiation complete bit wrong");
  fault_bit_a: assert property ((rd_a_addr_i == pmr_pkg::REG_STAT && !ctrl_r[2])
    |-> rd_a_data_o[4] == far_fault_i)
    else $error("far end fault bit wrong");
  an_capable_a: assert property ((rd_a_addr_i == pmr_pkg::REG_STAT) |-> rd_a_data_o[3] && !rd_a_data_o[0])
    else $error("capability or extended bit wrong");
  id_words_a: assert property ((rd_a_addr_i == pmr_pkg::REG_ID_LO) |-> rd_a_data_o == pmr_pkg::ID_LOWER_WORD)
    else $error("identifier word wrong");
  adv_write_a: assert property ((wr_i && wr_addr_i == pmr_pkg::REG_ADV)
    |=> adv_r[10:5] == ($past(wr_data_i[10:5]) & 6'h2f) && adv_r[4:0] == 5'h01)
    else $error("advertisement write not taken");
  restart_pulse_a: assert property (restart_r |=> !restart_r || $past(wr_i))
    else $error("restart pulse held");
  rsvd_zero_a: assert property ((rd_a_addr_i == pmr_pkg::REG_CTRL) |-> rd_a_data_o[15:14] == 2'h0
    && rd_a_data_o[10:9] == 2'h0 && rd_a_data_o[7:5] == 3'h0)
    else $error("reserved control bit set");
endmodule : pmr_port_regs
`default_nettype wire

// [hw/pmr_mgmt_regs.sv]
// Management serial slave and host port over the two PHY register sets
`default_nettype none
module pmr_mgmt_regs (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic center_mode_i,
  input wire logic prog_addr_valid_i,
  input wire logic [4:0] prog_phy_addr_i,
  input wire logic alt_port_i,
  input wire logic [4:0] alt_addr_i,
  input wire logic alt_wr_i,
  input wire logic alt_rd_i,
  input wire logic [15:0] alt_wdata_i,
  output logic [15:0] alt_rdata_o,
  input wire logic [1:0] an_complete_i,
  input wire logic [1:0] far_fault_i,
  input wire logic [1:0] link_up_i,
  output logic [1:0] force_100_o,
  output logic [1:0] an_enable_o,
  output logic [1:0] power_down_o,
  output logic [1:0] restart_an_o,
  output logic [1:0] full_duplex_o,
  output logic [1:0] force_mdi_o,
  output logic [1:0] mdix_disable_o,
  output logic [1:0] far_fault_disable_o,
  output logic [1:0] tx_disable_o,
  output logic [1:0] led_disable_o,
  output logic [1:0] adv_pause_o,
  output logic [1:0] adv_100_full_o,
  output logic [1:0] adv_100_half_o,
  output logic [1:0] adv_10_full_o,
  output logic [1:0] adv_10_half_o
);
  // Pin synchronisers; edge detect compares the second stage with its delayed copy
  logic mdc_s1_r, mdc_s2_r, mdc_d_r;
  logic mdio_s1_r, mdio_s2_r;
  logic rise_w;
  logic bit_w;

  // Serial engine state
  pmr_pkg::pmr_state_e st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [15:0] sh_in_w;
  logic op_rd_r, op_rd_nxt;
  logic op_ok_r, op_ok_nxt;
  logic hit_r, hit_nxt;
  logic port_r, port_nxt;
  logic [4:0] reg_r, reg_nxt;
  logic oe_r, oe_nxt;
  logic out_r, out_nxt;
  logic commit_w;
  logic hit_p0_w, hit_p1_w;

  // Host port state
  logic [15:0] alt_rdata_r, alt_rdata_nxt;

  // Per port wiring
  logic [1:0] wr_w;
  logic [4:0] wr_addr_w;
  logic [15:0] wr_data_w;
  logic [15:0] rd_a_w [2];
  logic [15:0] rd_b_w [2];
  logic [15:0] ctrl_w [2];
  logic [15:0] adv_w [2];

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      {mdc_s1_r, mdc_s2_r, mdc_d_r} <= 3'h0;
      {mdio_s1_r, mdio_s2_r} <= 2'h3;
    end
    else
    begin
      {mdc_s1_r, mdc_s2_r, mdc_d_r} <= {mdc_i, mdc_s1_r, mdc_s2_r};
      {mdio_s1_r, mdio_s2_r} <= {mdio_i, mdio_s1_r};
    end
  end
  // Data and clock share the same delay, so the sample stays aligned
  assign rise_w = mdc_s2_r && !mdc_d_r;
  assign bit_w = mdio_s2_r;
  assign sh_in_w = {sh_r[14:0], bit_w};

  // Address match on the completed address field
  always_comb
  begin
    hit_p0_w = 1'b0;
    hit_p1_w = 1'b0;
    if (center_mode_i)
    begin
      hit_p0_w = prog_addr_valid_i && sh_in_w[9:5] == prog_phy_addr_i;
    end
    else
    begin
      hit_p0_w = sh_in_w[9:5] == pmr_pkg::PHY_ADDR_P0;
      hit_p1_w = sh_in_w[9:5] == pmr_pkg::PHY_ADDR_P1;
    end
  end

  assign commit_w = st_r == pmr_pkg::PMR_WDAT && rise_w && cnt_r == pmr_pkg::DATA_BITS_LAST && hit_r;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    op_rd_nxt = op_rd_r;
    op_ok_nxt = op_ok_r;
    hit_nxt = hit_r;
    port_nxt = port_r;
    reg_nxt = reg_r;
    oe_nxt = oe_r;
    out_nxt = out_r;
    if (rise_w)
    begin
      case (st_r)
        pmr_pkg::PMR_PRE:
        begin
          // A long run of ones, then the first start bit
          if (bit_w)
          begin
            if (cnt_r != pmr_pkg::PREAMBLE_LEN)
              cnt_nxt = cnt_r + 6'h01;
          end
          else if (cnt_r == pmr_pkg::PREAMBLE_LEN)
          begin
            st_nxt = pmr_pkg::PMR_ST1;
            cnt_nxt = 6'h00;
          end
          else
          begin
            cnt_nxt = 6'h00;
          end
        end
        pmr_pkg::PMR_ST1:
        begin
          st_nxt = bit_w ? pmr_pkg::PMR_OPC : pmr_pkg::PMR_PRE;
          cnt_nxt = 6'h00;
        end
        pmr_pkg::PMR_OPC:
        begin
          sh_nxt = sh_in_w;
          if (cnt_r == 6'h01)
          begin
            // Only 10 (read) and 01 (write) are valid codes
            op_rd_nxt = sh_in_w[1:0] == 2'h2;
            op_ok_nxt = sh_in_w[1] ^ sh_in_w[0];
            st_nxt = pmr_pkg::PMR_ADDR;
            cnt_nxt = 6'h00;
          end
          else
          begin
            cnt_nxt = cnt_r + 6'h01;
          end
        end
        pmr_pkg::PMR_ADDR:
        begin
          sh_nxt = sh_in_w;
          if (cnt_r == pmr_pkg::ADDR_BITS_LAST)
          begin
            reg_nxt = sh_in_w[4:0];
            port_nxt = hit_p1_w;
            hit_nxt = op_ok_r && (hit_p0_w || hit_p1_w) && sh_in_w[4:0] <= pmr_pkg::REG_LAST;
            st_nxt = pmr_pkg::PMR_TA;
            cnt_nxt = 6'h00;
          end
          else
          begin
            cnt_nxt = cnt_r + 6'h01;
          end
        end
        pmr_pkg::PMR_TA:
        begin
          if (cnt_r == 6'h00)
          begin
            // Second turnaround bit is driven low on a read we own
            oe_nxt = op_rd_r && hit_r;
            out_nxt = 1'b0;
            cnt_nxt = 6'h01;
          end
          else
          begin
            sh_nxt = port_r ? rd_a_w[1] : rd_a_w[0];
            out_nxt = port_r ? rd_a_w[1][15] : rd_a_w[0][15];
            st_nxt = op_rd_r ? pmr_pkg::PMR_RDAT : pmr_pkg::PMR_WDAT;
            cnt_nxt = 6'h00;
          end
        end
        pmr_pkg::PMR_WDAT:
        begin
          sh_nxt = sh_in_w;
          if (cnt_r == pmr_pkg::DATA_BITS_LAST)
          begin
            st_nxt = pmr_pkg::PMR_PRE;
            cnt_nxt = 6'h00;
          end
          else
          begin
            cnt_nxt = cnt_r + 6'h01;
          end
        end
        pmr_pkg::PMR_RDAT:
        begin
          sh_nxt = {sh_r[14:0], 1'b0};
          out_nxt = sh_r[14];
          if (cnt_r == pmr_pkg::DATA_BITS_LAST)
          begin
            oe_nxt = 1'b0;
            out_nxt = 1'b0;
            st_nxt = pmr_pkg::PMR_PRE;
            cnt_nxt = 6'h00;
          end
          else
          begin
            cnt_nxt = cnt_r + 6'h01;
          end
        end
        default:
        begin
          st_nxt = pmr_pkg::PMR_PRE;
          cnt_nxt = 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_r <= pmr_pkg::PMR_PRE;
      cnt_r <= 6'h00;
      sh_r <= 16'h0000;
      reg_r <= 5'h00;
      {op_rd_r, op_ok_r, hit_r, port_r, oe_r, out_r} <= 6'h00;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      reg_r <= reg_nxt;
      {op_rd_r, op_ok_r, hit_r, port_r, oe_r, out_r} <= {op_rd_nxt, op_ok_nxt, hit_nxt, port_nxt, oe_nxt, out_nxt};
    end
  end
  assign mdio_o = out_r;
  assign mdio_oe_o = oe_r;

  // Serial write wins a same-cycle clash; the host write is dropped
  always_comb
  begin
    wr_w = 2'h0;
    wr_addr_w = alt_addr_i;
    wr_data_w = alt_wdata_i;
    if (commit_w)
    begin
      wr_w[port_r] = 1'b1;
      wr_addr_w = reg_r;
      wr_data_w = sh_in_w;
    end
    else if (alt_wr_i)
    begin
      wr_w[alt_port_i] = 1'b1;
    end
  end

  always_comb
  begin
    alt_rdata_nxt = alt_rdata_r;
    if (alt_rd_i)
      alt_rdata_nxt = alt_port_i ? rd_b_w[1] : rd_b_w[0];
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      alt_rdata_r <= 16'h0000;
    else
      alt_rdata_r <= alt_rdata_nxt;
  end

  assign alt_rdata_o = alt_rdata_r;

  genvar p;
  generate
    for (p = 0; p < pmr_pkg::NUM_PORTS; p++)
    begin : g_port
      pmr_port_regs u_regs (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .wr_i(wr_w[p]), .wr_addr_i(wr_addr_w), .wr_data_i(wr_data_w),
        .rd_a_addr_i(reg_r), .rd_a_data_o(rd_a_w[p]), .rd_b_addr_i(alt_addr_i), .rd_b_data_o(rd_b_w[p]),
        .an_complete_i(an_complete_i[p]), .far_fault_i(far_fault_i[p]), .link_up_i(link_up_i[p]),
        .ctrl_o(ctrl_w[p]), .adv_o(adv_w[p]), .restart_an_o(restart_an_o[p])
      );
      assign force_100_o[p] = ctrl_w[p][pmr_pkg::CTRL_FORCE_100];
      assign an_enable_o[p] = ctrl_w[p][pmr_pkg::CTRL_AN_EN];
      assign full_duplex_o[p] = ctrl_w[p][pmr_pkg::CTRL_FULL_DUP];
      assign power_down_o[p] = ctrl_w[p][pmr_pkg::CTRL_PWR_DOWN];
      assign tx_disable_o[p] = ctrl_w[p][pmr_pkg::CTRL_TX_DIS];
      assign led_disable_o[p] = ctrl_w[p][pmr_pkg::CTRL_LED_DIS];
      assign force_mdi_o[p] = ctrl_w[p][pmr_pkg::CTRL_FORCE_MDI];
      assign mdix_disable_o[p] = ctrl_w[p][pmr_pkg::CTRL_MDIX_DIS];
      assign far_fault_disable_o[p] = ctrl_w[p][pmr_pkg::CTRL_FEF_DIS];
      assign adv_pause_o[p] = adv_w[p][pmr_pkg::ADV_PAUSE];
      assign adv_100_full_o[p] = adv_w[p][pmr_pkg::ADV_100_FULL];
      assign adv_100_half_o[p] = adv_w[p][pmr_pkg::ADV_100_HALF];
      assign adv_10_full_o[p] = adv_w[p][pmr_pkg::ADV_10_FULL];
      assign adv_10_half_o[p] = adv_w[p][pmr_pkg::ADV_10_HALF];
    end
  endgenerate

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  drive_window_a: assert property (oe_r |-> (st_r == pmr_pkg::PMR_TA || st_r == pmr_pkg::PMR_RDAT))
    else $error("data pin driven outside a read");
  ta_low_a: assert property ($rose(oe_r) |-> !out_r && st_r == pmr_pkg::PMR_TA)
    else $error("turnaround not driven low");
  unsup_reg_a: assert property ((st_r == pmr_pkg::PMR_ADDR && rise_w && cnt_r == pmr_pkg::ADDR_BITS_LAST
    && sh_in_w[4:0] > pmr_pkg::REG_LAST) |=> !hit_r ##1 !oe_r)
    else $error("unsupported register answered");
  center_port_a: assert property ((center_mode_i && st_r == pmr_pkg::PMR_ADDR && rise_w
    && cnt_r == pmr_pkg::ADDR_BITS_LAST) |=> !port_r && (!hit_r || $past(prog_addr_valid_i)))
    else $error("center mode reached second port");
  host_read_a: assert property (alt_rd_i |=> alt_rdata_o == (($past(alt_port_i)) ? $past(rd_b_w[1])
    : $past(rd_b_w[0])))
    else $error("host read data wrong");
  mdi_follow_a: assert property ((commit_w && reg_r == pmr_pkg::REG_CTRL)
    |=> force_mdi_o[$past(port_r)] == $past(sh_in_w[4]) && mdix_disable_o[$past(port_r)] == $past(sh_in_w[3]))
    else $error("crossover controls not written");
  fef_mask_a: assert property ((far_fault_disable_o[0] && reg_r == pmr_pkg::REG_STAT) |-> !rd_a_w[0][4])
    else $error("fault shown while detection off");
  read_frame_a: assert property ((st_r == pmr_pkg::PMR_TA && oe_r && rise_w) |=> oe_r)
    else $error("read dropped after turnaround");

  read_cov_c: cover property (st_r == pmr_pkg::PMR_RDAT && cnt_r == pmr_pkg::DATA_BITS_LAST && rise_w && oe_r);
  write_cov_c: cover property (commit_w);
  center_cov_c: cover property (commit_w && center_mode_i);
  host_cov_c: cover property (alt_wr_i && !commit_w);
endmodule : pmr_mgmt_regs
`default_nettype wire

// [verif/pmr_mgmt_station.sv]
// Management station model for the serial management pins
`default_nettype none
module pmr_mgmt_station (
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic mdio_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Half period of a 10 MHz management clock
  localparam time HALF = 50ns;
  initial
  begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end
  // Clock stands low between frames; data moves only while it is low
  task automatic bit_out(input logic b);
    mdio_o = b;
    mdio_oe_o = 1'b1;
    #HALF mdc_o = 1'b1;
    #HALF mdc_o = 1'b0;
  endtask : bit_out
  task automatic xfer(input logic rd, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] q);
    logic [45:0] hdr;
    logic [17:0] wt;
    hdr = {32'hffff_ffff, 2'b01, rd ? 2'b10 : 2'b01, pa, ra};
    wt = {2'b10, wd};
    q = 16'h0000;
    for (int i = 45; i >= 0; i--) bit_out(hdr[i]);
    if (rd)
    begin
      mdio_oe_o = 1'b0;
      repeat (2)
      begin
        #HALF mdc_o = 1'b1;
        #HALF mdc_o = 1'b0;
      end
      // Sample late in the low phase, after the device has shifted
      for (int i = 0; i < 16; i++)
      begin
        #HALF q = {q[14:0], mdio_i};
        mdc_o = 1'b1;
        #HALF mdc_o = 1'b0;
      end
    end
    else
    begin
      for (int i = 17; i >= 0; i--) bit_out(wt[i]);
    end
    mdio_oe_o = 1'b0;
    #(4 * HALF);
  endtask : xfer
endmodule : pmr_mgmt_station
`default_nettype wire

// [verif/tb.sv]
// Testbench for the PHY management register set
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 30000;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic center = 1'b0;
  logic pvalid = 1'b0;
  logic [4:0] paddr = 5'h00;
  logic aport = 1'b0;
  logic [4:0] aaddr = 5'h00;
  logic awr = 1'b0;
  logic ard = 1'b0;
  logic [15:0] awd = 16'h0000;
  logic [15:0] ard_q;
  logic [1:0] anc = 2'b00;
  logic [1:0] ff = 2'b00;
  logic [1:0] lk = 2'b00;
  logic [1:0] f100, anen, pd, rst_an, fd, mdi, mdix, ffd, txd, ledd, ap, a100f, a100h, a10f, a10h;
  wire logic mdc, smo, soe, dmo, doe, mw;
  wire logic [15:0] p0_out, p1_out;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] q;
  // Pull-up on the shared data line when nobody drives it
  assign mw = doe ? dmo : (soe ? smo : 1'b1);
  assign p0_out = {2'b00, f100[0], anen[0], pd[0], fd[0], mdi[0], mdix[0], ffd[0], txd[0], ledd[0],
                   ap[0], a100f[0], a100h[0], a10f[0], a10h[0]};
  assign p1_out = {2'b00, f100[1], anen[1], pd[1], fd[1], mdi[1], mdix[1], ffd[1], txd[1], ledd[1],
                   ap[1], a100f[1], a100h[1], a10f[1], a10h[1]};
  always #2 clk_i = ~clk_i;
  pmr_mgmt_regs u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .mdc_i(mdc), .mdio_i(mw), .mdio_o(dmo),
    .mdio_oe_o(doe), .center_mode_i(center), .prog_addr_valid_i(pvalid), .prog_phy_addr_i(paddr),
    .alt_port_i(aport), .alt_addr_i(aaddr), .alt_wr_i(awr), .alt_rd_i(ard), .alt_wdata_i(awd),
    .alt_rdata_o(ard_q), .an_complete_i(anc), .far_fault_i(ff), .link_up_i(lk), .force_100_o(f100),
    .an_enable_o(anen), .power_down_o(pd), .restart_an_o(rst_an), .full_duplex_o(fd), .force_mdi_o(mdi),
    .mdix_disable_o(mdix), .far_fault_disable_o(ffd), .tx_disable_o(txd), .led_disable_o(ledd),
    .adv_pause_o(ap), .adv_100_full_o(a100f), .adv_100_half_o(a100h), .adv_10_full_o(a10f),
    .adv_10_half_o(a10h));
  pmr_mgmt_station u_sta (.mdc_o(mdc), .mdio_o(smo), .mdio_oe_o(soe), .mdio_i(mw));
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic hw(input logic p, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    aport = p;
    aaddr = a;
    awd = d;
    awr = 1'b1;
    @(posedge clk_i);
    #1;
    awr = 1'b0;
  endtask : hw
  task automatic hr(input logic p, input logic [4:0] a);
    @(posedge clk_i);
    #1;
    aport = p;
    aaddr = a;
    ard = 1'b1;
    @(posedge clk_i);
    #1;
    ard = 1'b0;
    q = ard_q;
  endtask : hr
  task automatic t_reset();
    chk("outputs", 16'h101f, p0_out);
    chk("outputs p1", 16'h101f, p1_out);
    hr(1'b0, 5'h00);
    chk("control", 16'h1000, q);
    hr(1'b0, 5'h04);
    chk("advert", 16'h05e1, q);
    hr(1'b1, 5'h01);
    chk("status", 16'h7808, q);
    hr(1'b1, 5'h02);
    chk("id upper", pmr_pkg::ID_UPPER_WORD, q);
    hr(1'b1, 5'h03);
    chk("id lower", pmr_pkg::ID_LOWER_WORD, q);
    hr(1'b0, 5'h06);
    chk("unmapped", 16'h0000, q);
    $display("test reset done");
  endtask : t_reset
  task automatic t_host();
    hw(1'b0, 5'h00, 16'hffff);
    chk("restart", 16'h0001, {14'h0000, rst_an});
    @(posedge clk_i);
    #1;
    chk("restart end", 16'h0000, {14'h0000, rst_an});
    hw(1'b0, 5'h04, 16'h0000);
    hw(1'b0, 5'h01, 16'hffff);
    hr(1'b0, 5'h00);
    chk("control rb", 16'h391f, q);
    hr(1'b0, 5'h04);
    chk("advert rb", 16'h0001, q);
    chk("outputs", 16'h3fe0, p0_out);
    hr(1'b0, 5'h01);
    chk("status ro", 16'h7808, q);
    $display("test host done");
  endtask : t_host
  task automatic t_status();
    anc = 2'b11;
    ff = 2'b11;
    lk = 2'b11;
    hr(1'b1, 5'h01);
    chk("status up", 16'h783c, q);
    // Port zero has far-end detection switched off
    hr(1'b0, 5'h01);
    chk("status fef", 16'h782c, q);
    anc = 2'b00;
    ff = 2'b00;
    lk = 2'b00;
    hr(1'b1, 5'h01);
    chk("status down", 16'h7808, q);
    $display("test status done");
  endtask : t_status
  task automatic t_serial();
    u_sta.xfer(1'b1, 5'h01, 5'h00, 16'h0000, q);
    chk("ser control", 16'h391f, q);
    u_sta.xfer(1'b0, 5'h01, 5'h00, 16'h0010, q);
    chk("ser mdi", 16'h0200, p0_out);
    u_sta.xfer(1'b0, 5'h02, 5'h04, 16'h0000, q);
    hr(1'b1, 5'h04);
    chk("ser write", 16'h0001, q);
    chk("p1 outputs", 16'h1000, p1_out);
    u_sta.xfer(1'b1, 5'h02, 5'h03, 16'h0000, q);
    chk("ser id", pmr_pkg::ID_LOWER_WORD, q);
    u_sta.xfer(1'b1, 5'h03, 5'h00, 16'h0000, q);
    chk("ser other", 16'hffff, q);
    u_sta.xfer(1'b1, 5'h01, 5'h06, 16'h0000, q);
    chk("ser unmapped", 16'hffff, q);
    $display("test serial done");
  endtask : t_serial
  task automatic t_center();
    @(posedge clk_i);
    #1;
    center = 1'b1;
    paddr = 5'h07;
    u_sta.xfer(1'b1, 5'h07, 5'h02, 16'h0000, q);
    chk("ctr unprog", 16'hffff, q);
    @(posedge clk_i);
    #1;
    pvalid = 1'b1;
    u_sta.xfer(1'b1, 5'h07, 5'h02, 16'h0000, q);
    chk("ctr port0", pmr_pkg::ID_UPPER_WORD, q);
    u_sta.xfer(1'b0, 5'h07, 5'h04, 16'h0400, q);
    hr(1'b0, 5'h04);
    chk("ctr write", 16'h0401, q);
    u_sta.xfer(1'b1, 5'h02, 5'h02, 16'h0000, q);
    chk("ctr port1", 16'hffff, q);
    $display("test center done");
  endtask : t_center
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_host();
    t_status();
    t_serial();
    t_center();
    end_sim();
  end
endmodule : tb
`default_nettype wire
